// File: shared/flash_host_pkg.sv
// package: flash host command codes, bus timing and carrier types
package flash_host_pkg;

   // ----------------------------------------------------------------
   // command codes written to the device, and the erased byte value
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_BLOCK = 8'h60;
   localparam logic [7:0] CMD_VERIFY = 8'ha0;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   // ----------------------------------------------------------------
   // addresses and field positions
   // ----------------------------------------------------------------
   localparam int ADDR_W = 17;
   localparam int BLOCK_SELECT_LOW = 14;
   localparam int TOGGLE_STATUS_BIT = 6;
   localparam int POLLING_STATUS_BIT = 7;
   localparam logic [16:0] ID_MFR_ADDR = 17'h00000;
   localparam logic [16:0] ID_DEV_ADDR = 17'h00001;

   // ----------------------------------------------------------------
   // timing, in ns (load window in ms) and derived cycles at the 40 ns clock
   // ----------------------------------------------------------------
   localparam int CLK_NS = 40;
   localparam int SETUP_NS = 120;
   localparam int STROBE_NS = 200;
   localparam int HOLD_NS = 80;
   localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int LOAD_WINDOW_MS = 30;
   localparam int LOAD_WINDOW_CYC = (LOAD_WINDOW_MS * 1000000 + CLK_NS - 1) / CLK_NS;
   localparam int POLL_MAX_READS = 16777215;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_BLOCK_ERASE, OP_VERIFY, OP_ABORT, OP_READ_ID
   } op_t;

   typedef struct packed {
      op_t op;
      logic [16:0] addr;
      logic [16:0] addr_end;
      logic [7:0] data;
      logic [7:0] blocks;
   } req_t;

   typedef struct packed {
      logic [7:0] rdata;
      logic [7:0] rdata2;
      logic fail;
      logic [16:0] last_addr;
   } rsp_t;

   typedef struct packed {
      logic [16:0] addr;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [7:0] dq_o;
      logic dq_oe_n;
   } pins_t;

   localparam pins_t PINS_IDLE = '{addr: 17'h00000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                   dq_o: 8'h00, dq_oe_n: 1'b1};

endpackage

// File: hdl/flash_bus_cycle.sv
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic start,
   input wire logic write,
   input wire logic [16:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] dq_i,
   output flash_host_pkg::pins_t pins,
   output logic [7:0] rdata,
   output logic done,
   output logic busy
);
   import flash_host_pkg::*;

   typedef enum logic [1:0] {
      C_IDLE = 2'b00, C_SETUP = 2'b01, C_STROBE = 2'b11, C_HOLD = 2'b10
   } cyc_st_t;

   cyc_st_t st_q;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic wr_q;
   logic [7:0] dq_s1_q;
   logic [7:0] dq_s2_q;
   pins_t pins_q;
   logic [7:0] rdata_q;
   logic done_q;
   wire logic phase_end;

   assign phase_end = (cnt_q == 4'h1);
   assign cnt_d = (st_q == C_IDLE) ? 4'(SETUP_CYC) :
                  !phase_end ? cnt_q - 4'h1 :
                  (st_q == C_SETUP) ? 4'(STROBE_CYC) : 4'(HOLD_CYC);

   // ----------------------------------------------------------------
   // data pins pass two flops before anything looks at them
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dq_s1_q <= 8'h00;
         dq_s2_q <= 8'h00;
         cnt_q <= 4'(SETUP_CYC);
      end else if (en) begin
         dq_s1_q <= dq_i;
         dq_s2_q <= dq_s1_q;
         cnt_q <= cnt_d;
      end
   end

   // ----------------------------------------------------------------
   // phase sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= C_IDLE;
         wr_q <= 1'b0;
         pins_q <= PINS_IDLE;
         rdata_q <= 8'h00;
         done_q <= 1'b0;
      end else if (en) begin
         done_q <= 1'b0;
         case (st_q)
            C_IDLE: if (start) begin
               st_q <= C_SETUP;
               wr_q <= write;
               pins_q.addr <= addr;
               pins_q.ce_n <= 1'b0;
               pins_q.dq_o <= wdata;
               pins_q.dq_oe_n <= !write;
            end
            C_SETUP: if (phase_end) begin
               st_q <= C_STROBE;
               pins_q.we_n <= !wr_q; // address taken by the device here
               pins_q.oe_n <= wr_q;
            end
            C_STROBE: if (phase_end) begin
               st_q <= C_HOLD;
               pins_q.we_n <= 1'b1; // data held across the rising edge
               pins_q.oe_n <= 1'b1;
               // synced copy lags two cycles, still inside the strobe
               if (!wr_q) rdata_q <= dq_s2_q;
            end
            C_HOLD: if (phase_end) begin
               st_q <= C_IDLE;
               pins_q.ce_n <= 1'b1;
               pins_q.dq_oe_n <= 1'b1;
               done_q <= 1'b1;
            end
            default: st_q <= C_IDLE;
         endcase
      end
   end

   assign pins = pins_q;
   assign rdata = rdata_q;
   assign done = done_q;
   assign busy = (st_q != C_IDLE);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   strobe_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
      !(!pins_q.we_n && !pins_q.oe_n))
      else $error("read and write strobes low together");
   we_rise_data_a: assert property (@(posedge clk) disable iff (!rst_n || !en)
      $rose(pins_q.we_n) |-> !pins_q.dq_oe_n && $stable(pins_q.addr) && $stable(pins_q.dq_o))
      else $error("address or data moved across write strobe");
   we_width_a: assert property (@(posedge clk) disable iff (!rst_n || !en)
      $fell(pins_q.we_n) |-> (!pins_q.we_n && !pins_q.ce_n)[*5] ##1 pins_q.we_n)
      else $error("write strobe width wrong");
endmodule
`default_nettype wire

// File: hdl/flash_host.sv
// host sequencer that drives a byte-wide flash through its pins
`timescale 1ns/1ps
`default_nettype none
module flash_host #(
   parameter int WINDOW_CYCLES = flash_host_pkg::LOAD_WINDOW_CYC,
   parameter int POLL_LIMIT = flash_host_pkg::POLL_MAX_READS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic req_valid,
   input wire flash_host_pkg::req_t req,
   output logic req_ready,
   output logic rsp_valid,
   output flash_host_pkg::rsp_t rsp,
   input wire logic [7:0] dq_i,
   output flash_host_pkg::pins_t pins,
   output logic vpp_en
);
   import flash_host_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0, S_FIRST = 4'h1, S_SECOND = 4'h3, S_POLL = 4'h2, S_DONE = 4'h6,
      S_LOAD = 4'h7, S_WINDOW = 4'h5, S_READ = 4'h4, S_CLEAN = 4'hc
   } st_t;

   st_t st_q;
   st_t st_d;
   op_t op_q;
   logic [16:0] addr_q;
   logic [16:0] end_q;
   logic [7:0] data_q;
   logic [7:0] blk_q;
   logic sent_q;
   logic start_q;
   logic [7:0] prev_q;
   logic prev_v_q;
   logic fail_q;
   logic [31:0] win_q;
   logic [31:0] polls_q;
   logic vpp_q;
   logic req_ready_q;
   logic rsp_valid_q;
   rsp_t rsp_q;
   logic [7:0] rd;
   logic cyc_done;
   logic cyc_busy;

   function automatic logic [2:0] lowest_set(input logic [7:0] m);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (m[i]) idx = 3'(i);
      end
      return idx;
   endfunction

   // ----------------------------------------------------------------
   // decode of what the current state puts on the bus
   // ----------------------------------------------------------------
   wire logic accept = (st_q == S_IDLE) && req_valid && req_ready_q;
   wire logic bus_state = (st_q != S_IDLE) && (st_q != S_DONE) && (st_q != S_WINDOW);
   wire logic cyc_write = (st_q != S_POLL) && (st_q != S_READ);
   wire logic [2:0] blk_idx = lowest_set(blk_q);
   wire logic [7:0] blk_rest = blk_q & ~(8'h01 << blk_idx);
   wire logic [16:0] blk_addr = {blk_idx, 14'h0000};
   wire logic is_block = (op_q == OP_BLOCK_ERASE);
   wire logic [7:0] first_code =
      (op_q == OP_PROGRAM) ? CMD_PROGRAM :
      (op_q == OP_CHIP_ERASE) ? CMD_ERASE :
      is_block ? CMD_BLOCK :
      (op_q == OP_VERIFY) ? CMD_VERIFY :
      (op_q == OP_READ_ID) ? CMD_READ_ID :
      CMD_RESET;
   // second write repeats the setup code except for program data
   wire logic [7:0] cyc_data = (st_q == S_CLEAN) ? CMD_READ :
      (st_q == S_SECOND && op_q == OP_PROGRAM) ? data_q : first_code;
   wire logic [16:0] cyc_addr =
      ((st_q == S_SECOND || st_q == S_LOAD) && is_block) ? blk_addr : addr_q;

   // ----------------------------------------------------------------
   // status decode while an algorithm runs
   // ----------------------------------------------------------------
   wire logic toggle_steady = prev_v_q &&
      (rd[TOGGLE_STATUS_BIT] == prev_q[TOGGLE_STATUS_BIT]);
   wire logic prog_ok = toggle_steady &&
      (rd[POLLING_STATUS_BIT:TOGGLE_STATUS_BIT] == data_q[POLLING_STATUS_BIT:TOGGLE_STATUS_BIT]);
   wire logic erase_ok = toggle_steady && rd[POLLING_STATUS_BIT];
   wire logic poll_ok = (op_q == OP_PROGRAM) ? prog_ok : erase_ok;
   wire logic poll_out = (polls_q >= 32'(POLL_LIMIT));
   wire logic win_done = (win_q >= 32'(WINDOW_CYCLES));
   wire logic verify_bad = (rd != ERASED_BYTE);
   wire logic verify_last = (addr_q == end_q);

   flash_bus_cycle u_cycle (
      .clk(clk),
      .rst_n(rst_n),
      .en(en),
      .start(start_q),
      .write(cyc_write),
      .addr(cyc_addr),
      .wdata(cyc_data),
      .dq_i(dq_i),
      .pins(pins),
      .rdata(rd),
      .done(cyc_done),
      .busy(cyc_busy)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      case (st_q)
         S_IDLE: if (accept) begin
            if (req.op == OP_READ) st_d = S_READ;
            else if (req.op == OP_BLOCK_ERASE && req.blocks == 8'h00) st_d = S_DONE;
            else st_d = S_FIRST;
         end
         S_FIRST: if (cyc_done) begin
            st_d = (op_q == OP_VERIFY || op_q == OP_READ_ID) ? S_READ : S_SECOND;
         end
         S_SECOND: if (cyc_done) begin
            if (op_q == OP_ABORT) st_d = S_CLEAN;
            else if (!is_block) st_d = S_POLL;
            else st_d = (blk_rest != 8'h00) ? S_LOAD : S_WINDOW;
         end
         S_LOAD: if (cyc_done) st_d = (blk_rest != 8'h00) ? S_LOAD : S_WINDOW;
         S_WINDOW: if (win_done) st_d = S_POLL;
         S_POLL: if (cyc_done) begin
            if (poll_ok) st_d = S_DONE;
            else if (poll_out) st_d = S_FIRST;
         end
         S_READ: if (cyc_done) begin
            if (op_q == OP_READ) st_d = S_DONE;
            else if (op_q == OP_READ_ID) st_d = (addr_q == ID_MFR_ADDR) ? S_READ : S_CLEAN;
            else st_d = (verify_bad || verify_last) ? S_CLEAN : S_FIRST;
         end
         S_CLEAN: if (cyc_done) st_d = S_DONE;
         S_DONE: st_d = S_IDLE;
         default: st_d = S_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // state, launch and working registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= S_IDLE;
         sent_q <= 1'b0;
         start_q <= 1'b0;
         req_ready_q <= 1'b0;
      end else if (en) begin
         st_q <= st_d;
         req_ready_q <= (st_d == S_IDLE) && !accept;
         start_q <= bus_state && !sent_q && !cyc_busy && !start_q;
         if (cyc_done) sent_q <= 1'b0;
         else if (start_q) sent_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         op_q <= OP_READ;
         addr_q <= 17'h00000;
         end_q <= 17'h00000;
         data_q <= 8'h00;
         blk_q <= 8'h00;
         prev_q <= 8'h00;
         prev_v_q <= 1'b0;
         fail_q <= 1'b0;
         win_q <= 32'h00000000;
         polls_q <= 32'h00000000;
         vpp_q <= 1'b0;
      end else if (en) begin
         if (accept) begin
            op_q <= req.op;
            addr_q <= (req.op == OP_READ_ID) ? ID_MFR_ADDR : req.addr;
            end_q <= req.addr_end;
            data_q <= req.data;
            blk_q <= req.blocks;
            prev_v_q <= 1'b0;
            fail_q <= (req.op == OP_BLOCK_ERASE) && (req.blocks == 8'h00);
            win_q <= 32'h00000000;
            polls_q <= 32'h00000000;
            vpp_q <= (req.op != OP_READ);
         end
         if (cyc_done && is_block && (st_q == S_SECOND || st_q == S_LOAD)) blk_q <= blk_rest;
         if (st_q == S_WINDOW) win_q <= win_q + 32'h00000001;
         if (cyc_done && st_q == S_POLL) begin
            prev_q <= rd;
            prev_v_q <= 1'b1;
            polls_q <= polls_q + 32'h00000001;
            if (!poll_ok && poll_out) begin
               op_q <= OP_ABORT;
               fail_q <= 1'b1;
            end
         end
         if (cyc_done && st_q == S_READ) begin
            if (op_q == OP_READ_ID && addr_q == ID_MFR_ADDR) addr_q <= ID_DEV_ADDR;
            if (op_q == OP_VERIFY && verify_bad) fail_q <= 1'b1;
            else if (op_q == OP_VERIFY && !verify_last) addr_q <= addr_q + 17'h00001;
         end
         if (st_q == S_DONE) vpp_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // answer to the user
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rsp_valid_q <= 1'b0;
         rsp_q <= '0;
      end else if (en) begin
         rsp_valid_q <= (st_q == S_DONE);
         if (cyc_done && (st_q == S_POLL || st_q == S_READ)) begin
            if (op_q == OP_READ_ID && addr_q == ID_DEV_ADDR) rsp_q.rdata2 <= rd;
            else rsp_q.rdata <= rd;
         end
         if (st_q == S_DONE) begin
            rsp_q.fail <= fail_q;
            rsp_q.last_addr <= addr_q;
         end
      end
   end

   assign req_ready = req_ready_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp = rsp_q;
   assign vpp_en = vpp_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence setup_write_s;
      (st_q == S_FIRST) && cyc_done;
   endsequence

   program_setup_a: assert property (@(posedge clk) disable iff (!rst_n || !en)
      $fell(pins.we_n) && st_q == S_FIRST && op_q == OP_PROGRAM |-> pins.dq_o == 8'h40)
      else $error("program setup code wrong");
   chip_twice_a: assert property (@(posedge clk) disable iff (!rst_n || !en)
      (st_q == S_SECOND) && cyc_done && op_q == OP_CHIP_ERASE |-> pins.dq_o == 8'h20
      ##1 st_q == S_POLL)
      else $error("chip erase second write wrong");
   vpp_high_a: assert property (@(posedge clk) disable iff (!rst_n)
      !pins.we_n && op_q != OP_READ |-> vpp_q)
      else $error("write strobe without programming voltage");
   window_hold_a: assert property (@(posedge clk) disable iff (!rst_n || !en)
      st_q == S_WINDOW && !win_done |=> st_q == S_WINDOW)
      else $error("status polled before load window closed");
   window_empty_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_q == S_WINDOW |-> blk_q == 8'h00)
      else $error("block flags left unloaded");
   verify_read_a: assert property (@(posedge clk) disable iff (!rst_n || !en)
      setup_write_s and (op_q == OP_VERIFY) |-> pins.dq_o == 8'ha0 ##1 st_q == S_READ)
      else $error("verify read not preceded by verify command");
   verify_fail_a: assert property (@(posedge clk) disable iff (!rst_n || !en)
      st_q == S_READ && op_q == OP_VERIFY && cyc_done && rd != 8'hff
      |=> fail_q && st_q == S_CLEAN)
      else $error("verify failure not caught");
   abort_pair_a: assert property (@(posedge clk) disable iff (!rst_n || !en)
      setup_write_s and (op_q == OP_ABORT) |-> pins.dq_o == 8'hff ##1 st_q == S_SECOND)
      else $error("abort not issued as a pair");
   abort_clean_a: assert property (@(posedge clk) disable iff (!rst_n || !en)
      st_q == S_SECOND && op_q == OP_ABORT && cyc_done |=> st_q == S_CLEAN)
      else $error("no valid command after abort");
   poll_done_a: assert property (@(posedge clk) disable iff (!rst_n || !en)
      st_q == S_POLL && cyc_done && poll_ok |=> st_q == S_DONE ##1 rsp_valid_q)
      else $error("finished algorithm not reported");
endmodule
`default_nettype wire

// File: sim/flash_device_model.sv
// behavioural byte-wide flash device answering the host's pin cycles
`timescale 1ns/1ps
`default_nettype none
module flash_device_model #(
   parameter int BUSY_READS = 3,
   parameter int WIN = 16,
   parameter logic [7:0] MFR_CODE = 8'h5e, // arbitrary value
   parameter logic [7:0] DEV_CODE = 8'h3c // arbitrary value
) (
   input wire logic clk,
   input wire flash_host_pkg::pins_t pins,
   input wire logic vpp_en,
   output logic [7:0] dq
);
   import flash_host_pkg::*;
   typedef enum {M_READ, M_ID, M_PSET, M_ESET, M_BSET, M_BLOAD, M_VER, M_BUSYP, M_BUSYE} mode_t;
   mode_t mode = M_READ;
   logic [7:0] mem [0:131071];
   logic [7:0] rd_q = 8'h00;
   logic [7:0] last_q = 8'h00;
   logic [7:0] pd_q = 8'h00;
   logic [7:0] flags = 8'h00;
   logic [16:0] a_q = 17'h00000;
   logic [16:0] va_q = 17'h00000;
   logic tog = 1'b0;
   logic ff_q = 1'b0;
   logic drive = 1'b0;
   int left = 0;
   realtime t_rise = 0;
   wire busy = (mode == M_BUSYP) || (mode == M_BUSYE);
   initial foreach (mem[i]) mem[i] = ERASED_BYTE;
   // released bus shows the inverse of the last byte, never a held value
   assign dq = drive ? rd_q : ~last_q;
   // ---------------------------------------------
   // command writes
   // ---------------------------------------------
   always @(negedge pins.we_n) if (!pins.ce_n) a_q = pins.addr;
   always @(posedge pins.we_n) begin
      t_rise = $realtime;
      if (!vpp_en) mode = M_READ;
      else if (!busy) begin
         if (pins.dq_o == CMD_RESET) begin
            if (ff_q) mode = M_READ;
            ff_q = !ff_q;
         end else begin
            ff_q = 1'b0;
            case (mode)
               M_PSET: begin
                  pd_q = pins.dq_o;
                  mem[a_q] = mem[a_q] & pins.dq_o;
                  left = BUSY_READS;
                  mode = M_BUSYP;
               end
               M_ESET: if (pins.dq_o == CMD_ERASE) begin
                  foreach (mem[i]) mem[i] = ERASED_BYTE;
                  left = BUSY_READS;
                  mode = M_BUSYE;
               end else mode = M_READ;
               M_BSET, M_BLOAD: if (pins.dq_o == CMD_BLOCK) begin
                  flags[a_q[16:14]] = 1'b1;
                  mode = M_BLOAD;
               end else mode = M_READ;
               default: begin
                  va_q = a_q;
                  case (pins.dq_o)
                     CMD_PROGRAM: mode = M_PSET;
                     CMD_ERASE: mode = M_ESET;
                     CMD_BLOCK: mode = M_BSET;
                     CMD_VERIFY: mode = M_VER;
                     CMD_READ_ID: mode = M_ID;
                     default: mode = M_READ;
                  endcase
               end
            endcase
         end
      end
   end
   // load window closes when no new load starts in time
   always @(posedge clk) if (mode == M_BLOAD && $realtime - t_rise >= WIN * CLK_NS) begin
      foreach (mem[i]) if (flags[i >> 14]) mem[i] = ERASED_BYTE;
      flags = 8'h00;
      left = BUSY_READS;
      mode = M_BUSYE;
   end
   // ---------------------------------------------
   // reads and status
   // ---------------------------------------------
   always @(negedge pins.oe_n) begin
      drive = !pins.ce_n;
      case (mode)
         M_BUSYP: rd_q = {~pd_q[7], tog, mem[pins.addr][5:0]};
         M_BUSYE: rd_q = {1'b0, tog, 6'h00};
         M_ID: rd_q = pins.addr[0] ? DEV_CODE : MFR_CODE;
         M_VER: rd_q = mem[va_q];
         default: rd_q = mem[pins.addr];
      endcase
   end
   always @(posedge pins.oe_n) begin
      drive = 1'b0;
      last_q = rd_q;
      if (busy) begin
         tog = !tog;
         left = left - 1;
         if (left == 0) mode = M_READ;
      end
   end
endmodule
`default_nettype wire

// File: sim/tb.sv
// testbench: user requests into the flash host against a behavioural flash
`timescale 1ns/1ps
`default_nettype none
module tb;
   import flash_host_pkg::*;
   localparam logic [7:0] MFR = 8'h5e; // arbitrary value
   localparam logic [7:0] DEV = 8'h3c; // arbitrary value
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   logic en = 1'b1;
   req_t req = '0;
   logic req_ready;
   logic rsp_valid;
   logic vpp_en;
   rsp_t rsp;
   rsp_t got;
   logic [7:0] dq_i;
   pins_t pins;
   int n_fail = 0;
   int n_tests = 0;
   always #20 clk = ~clk;
   flash_host #(.WINDOW_CYCLES(20), .POLL_LIMIT(50)) flash_host_inst (.clk(clk), .rst_n(rst_n),
      .en(en), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp(rsp), .dq_i(dq_i), .pins(pins), .vpp_en(vpp_en));
   flash_device_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash_device_model_inst (.clk(clk),
      .pins(pins), .vpp_en(vpp_en), .dq(dq_i));
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] seen);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic run(input op_t op, input logic [16:0] a, input logic [16:0] a2,
      input logic [7:0] d, input logic [7:0] blk);
      int k;
      @(negedge clk);
      for (k = 0; k < 100 && req_ready !== 1'b1; k++) @(negedge clk);
      req = '{op: op, addr: a, addr_end: a2, data: d, blocks: blk};
      req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
      for (k = 0; k < 20000 && rsp_valid !== 1'b1; k++) @(negedge clk);
      chk("rsp_valid", 17'h1, {16'h0, rsp_valid});
      got = rsp;
   endtask
   // every write strobe must see the programming voltage requested
   always @(negedge pins.we_n) if (rst_n) chk("vpp_en at write", 17'h1, {16'h0, vpp_en});
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic s_ident();
      run(OP_READ_ID, 17'h0, 17'h0, 8'h00, 8'h00);
      chk("id maker", {9'h0, MFR}, {9'h0, got.rdata});
      chk("id device", {9'h0, DEV}, {9'h0, got.rdata2});
   endtask
   task automatic s_program();
      run(OP_PROGRAM, 17'h00123, 17'h0, 8'h5a, 8'h00);
      chk("prog fail", 17'h0, {16'h0, got.fail});
      chk("prog final", 17'h5a, {9'h0, got.rdata});
      run(OP_READ, 17'h00123, 17'h0, 8'h00, 8'h00);
      chk("prog read", 17'h5a, {9'h0, got.rdata});
      run(OP_PROGRAM, 17'h04000, 17'h0, 8'h33, 8'h00);
      chk("prog2 fail", 17'h0, {16'h0, got.fail});
   endtask
   // enable held low mid read: pins must stand still, data still arrives
   task automatic s_freeze();
      fork
         run(OP_READ, 17'h00123, 17'h0, 8'h00, 8'h00);
         begin
            repeat (9) @(negedge clk);
            en = 1'b0;
            repeat (12) @(negedge clk);
            chk("frozen addr", 17'h00123, pins.addr);
            chk("frozen strobes", 17'h3, {13'h0, pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe_n});
            en = 1'b1;
         end
      join
      chk("frozen read", 17'h5a, {9'h0, got.rdata});
   endtask
   task automatic s_verify();
      run(OP_VERIFY, 17'h00120, 17'h00127, 8'h00, 8'h00);
      chk("verify fail", 17'h1, {16'h0, got.fail});
      chk("verify addr", 17'h00123, got.last_addr);
      run(OP_VERIFY, 17'h00200, 17'h00203, 8'h00, 8'h00);
      chk("verify clean", 17'h0, {16'h0, got.fail});
   endtask
   task automatic s_block();
      run(OP_BLOCK_ERASE, 17'h0, 17'h0, 8'h00, 8'h05);
      chk("block fail", 17'h0, {16'h0, got.fail});
      run(OP_READ, 17'h00123, 17'h0, 8'h00, 8'h00);
      chk("block erased", 17'hff, {9'h0, got.rdata});
      run(OP_READ, 17'h04000, 17'h0, 8'h00, 8'h00);
      chk("block kept", 17'h33, {9'h0, got.rdata});
      run(OP_BLOCK_ERASE, 17'h0, 17'h0, 8'h00, 8'h00);
      chk("no blocks", 17'h1, {16'h0, got.fail});
   endtask
   task automatic s_abort();
      run(OP_PROGRAM, 17'h04000, 17'h0, 8'hcc, 8'h00);
      chk("stuck prog", 17'h1, {16'h0, got.fail});
      run(OP_ABORT, 17'h0, 17'h0, 8'h00, 8'h00);
      chk("abort fail", 17'h0, {16'h0, got.fail});
      run(OP_PROGRAM, 17'h00300, 17'h0, 8'ha5, 8'h00);
      chk("after abort", 17'ha5, {9'h0, got.rdata});
   endtask
   task automatic s_chip();
      run(OP_PROGRAM, 17'h1ffff, 17'h0, 8'h00, 8'h00);
      chk("chip prep", 17'h0, {16'h0, got.fail});
      run(OP_CHIP_ERASE, 17'h0, 17'h0, 8'h00, 8'h00);
      chk("chip fail", 17'h0, {16'h0, got.fail});
      run(OP_VERIFY, 17'h1fff8, 17'h1ffff, 8'h00, 8'h00);
      chk("chip verify", 17'h0, {16'h0, got.fail});
      run(OP_READ, 17'h04000, 17'h0, 8'h00, 8'h00);
      chk("chip read", 17'hff, {9'h0, got.rdata});
   endtask
   initial begin
      #1_000_000;
      n_fail++;
      stop_test();
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      s_ident();
      s_program();
      s_freeze();
      s_verify();
      s_block();
      s_abort();
      s_chip();
      stop_test();
   end
endmodule
`default_nettype wire
